// file: design/slcs_compare.sv
// Per-texel depth compare for compare-type sample requests
`default_nettype none
module slcs_compare #(
    parameter int REF_W = 16
) (
    // Operands
    input  wire logic [2:0]       func,
    input  wire logic [REF_W-1:0] ref_val,
    input  wire logic [REF_W-1:0] texel,
    // Result
    output logic                  pass
);
    always_comb begin
        unique case (slcs_pkg::slcs_cmp_e'(func))
            slcs_pkg::compare_always_pass:      pass = 1'b1;
            slcs_pkg::compare_never_pass:       pass = 1'b0;
            slcs_pkg::compare_less:             pass = ref_val <  texel;
            slcs_pkg::compare_equal:            pass = ref_val == texel;
            slcs_pkg::compare_less_or_equal:    pass = ref_val <= texel;
            slcs_pkg::compare_greater:          pass = ref_val >  texel;
            slcs_pkg::compare_not_equal:        pass = ref_val != texel;
            slcs_pkg::compare_greater_or_equal: pass = ref_val >= texel;
        endcase
    end
endmodule
`default_nettype wire

// file: design/slcs_lod_clamp.sv
// LOD clamp, min/mag decision, aniso select and shadow compare stage
// Contract
// - One bit selects legacy or elliptical anisotropic
// - Lower clamp U4.8 bounds computed LOD below
// - Min/mag decided after bias, before clamps
// - Lower integer limits finest level; fraction clamps blend
// - Lower clamp wins over upper clamp
// - Upper clamp, 0 to 14, bounds biased LOD
// - Upper integer limits coarsest level; fraction clamps blend
// - Three-bit field selects shadow comparison
`default_nettype none
module slcs_lod_clamp #(
    parameter int REF_W = 16,
    parameter int TEX_N = 4
) (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    // Sampler state
    input  wire logic                      aniso_alg_sel,
    input  wire logic [11:0]               lower_detail_clamp,
    input  wire logic [11:0]               upper_detail_clamp,
    input  wire logic [2:0]                cmp_func,
    input  wire logic [2:0]                min_filter,
    input  wire logic [2:0]                mag_filter,
    input  wire logic                      trilinear_en,
    // Request
    input  wire logic                      req_valid,
    input  wire logic [12:0]               lod_in,
    input  wire logic [12:0]               lod_bias,
    input  wire logic                      req_compare,
    input  wire logic [REF_W-1:0]          ref_val,
    input  wire logic [TEX_N*REF_W-1:0]    texels,
    // Result
    output logic                           res_valid,
    output logic                           res_minify,
    output logic [11:0]                    res_lod,
    output logic [3:0]                     res_level,
    output logic [7:0]                     res_blend,
    output logic                           res_elliptical,
    output logic [TEX_N-1:0]               res_cmp,
    output logic                           cfg_mono_err
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // One decode for both filter fields so the two cannot drift apart
    function automatic logic is_mono(input logic [2:0] filt);
        return filt == slcs_pkg::MONO_FILTER;
    endfunction

    // Integer part of a U4.8 detail value names the mip level
    function automatic logic [slcs_pkg::LOD_INT_W-1:0] lod_level(input logic [slcs_pkg::LOD_W-1:0] lod);
        return lod[slcs_pkg::LOD_W-1:slcs_pkg::LOD_FRAC_W];
    endfunction

    // Fraction part of a U4.8 detail value is the trilinear weight
    function automatic logic [slcs_pkg::LOD_FRAC_W-1:0] lod_frac(input logic [slcs_pkg::LOD_W-1:0] lod);
        return lod[slcs_pkg::LOD_FRAC_W-1:0];
    endfunction

    // ------------------------------------------------------------
    // Biased LOD
    // ------------------------------------------------------------
    // One extra bit so the sum of two S4.8 values cannot wrap
    localparam int                      SUM_W       = slcs_pkg::BIAS_W + 1;
    localparam logic signed [SUM_W-1:0] BIASED_ZERO = '0;
    localparam logic signed [SUM_W-1:0] BIASED_TOP  = SUM_W'(slcs_pkg::LOD_MAX_CODE);

    logic signed [SUM_W-1:0]           biased;
    logic        [slcs_pkg::LOD_W-1:0] bsat;
    logic        [slcs_pkg::LOD_W-1:0] upper_eff;
    logic        [slcs_pkg::LOD_W-1:0] clamped;
    logic                              minify;
    logic                              mono_sel;
    logic        [TEX_N-1:0]           cmp_bits;

    // Sign-extend both operands before the add
    assign biased = SUM_W'(signed'(lod_in)) + SUM_W'(signed'(lod_bias));
    // Decided on the biased value before any clamp; zero counts as magnify
    assign minify = (biased > BIASED_ZERO);

    // Saturate to the U4.8 range so the clamps compare like with like
    always_comb begin
        if (biased < BIASED_ZERO) begin
            bsat = slcs_pkg::LOD_ZERO;
        end else if (biased > BIASED_TOP) begin
            bsat = slcs_pkg::LOD_MAX_CODE;
        end else begin
            bsat = biased[slcs_pkg::LOD_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Detail clamps
    // ------------------------------------------------------------
    // Upper field is held to 14.0 even if software overprograms it
    assign upper_eff = (upper_detail_clamp > slcs_pkg::UPPER_MAX) ? slcs_pkg::UPPER_MAX
                                                                  : upper_detail_clamp;

    always_comb begin
        // Lower applied last so it takes precedence when above upper
        clamped = (bsat > upper_eff) ? upper_eff : bsat;
        if (clamped < lower_detail_clamp) begin
            clamped = lower_detail_clamp;
        end
    end

    // ------------------------------------------------------------
    // Compare lanes
    // ------------------------------------------------------------
    // Every lane shares the function and the reference value
    genvar gi;
    generate
        for (gi = 0; gi < TEX_N; gi++) begin : g_cmp
            slcs_compare #(.REF_W(REF_W)) u_cmp (
                .func    (cmp_func),
                .ref_val (ref_val),
                .texel   (texels[gi*REF_W +: REF_W]),
                .pass    (cmp_bits[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Result strobe
    // ------------------------------------------------------------
    // One result per request, exactly one edge later
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= req_valid;
        end
    end

    // ------------------------------------------------------------
    // Minify flag
    // ------------------------------------------------------------
    // Taken from the biased value, never from the clamped one
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            res_minify <= 1'b0;
        end else begin
            res_minify <= minify;
        end
    end

    // ------------------------------------------------------------
    // Clamped LOD
    // ------------------------------------------------------------
    // Results refresh every edge; consumers qualify them with res_valid
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            res_lod <= slcs_pkg::LOD_ZERO;
        end else begin
            res_lod <= clamped;
        end
    end

    // ------------------------------------------------------------
    // Mip level
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            res_level <= slcs_pkg::BASE_LEVEL;
        end else begin
            res_level <= lod_level(clamped);
        end
    end

    // ------------------------------------------------------------
    // Blend weight
    // ------------------------------------------------------------
    // Without trilinear there is no second level to blend toward
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            res_blend <= slcs_pkg::BLEND_ZERO;
        end else begin
            res_blend <= trilinear_en ? lod_frac(clamped) : slcs_pkg::BLEND_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Anisotropic algorithm
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            res_elliptical <= 1'b0;
        end else begin
            res_elliptical <= (aniso_alg_sel == slcs_pkg::elliptical_weighted_approx);
        end
    end

    // ------------------------------------------------------------
    // Shadow compare
    // ------------------------------------------------------------
    // Plain samples report no pass bits, so stale lanes never leak out
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            res_cmp <= '0;
        end else begin
            res_cmp <= req_compare ? cmp_bits : '0;
        end
    end

    // ------------------------------------------------------------
    // Configuration check
    // ------------------------------------------------------------
    // Lower clamp must be zero whenever either filter is monochrome
    assign mono_sel = is_mono(min_filter) || is_mono(mag_filter);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_mono_err <= 1'b0;
        end else begin
            cfg_mono_err <= mono_sel && (lower_detail_clamp != slcs_pkg::LOD_ZERO);
        end
    end
endmodule
`default_nettype wire

// file: design/slcs_pkg.sv
// Package: constants for the sampler LOD clamp and shadow compare block
`default_nettype none
package slcs_pkg;
    // ------------------------------------------------------------
    // Field widths and layout
    // ------------------------------------------------------------
    localparam int LOD_INT_W  = 4;
    localparam int LOD_FRAC_W = 8;
    localparam int LOD_W      = LOD_INT_W + LOD_FRAC_W;
    localparam int BIAS_W     = 13;
    localparam int CMP_LSB    = 1;
    localparam int CMP_MSB    = 3;
    localparam int RSV_LSB    = 4;
    localparam int RSV_MSB    = 7;
    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [LOD_W-1:0] LOD_ZERO      = 12'h000;
    localparam logic [LOD_W-1:0] UPPER_MAX     = 12'hE00;
    localparam logic [LOD_W-1:0] LOD_MAX_CODE  = 12'hFFF;
    localparam logic [3:0]       BASE_LEVEL    = 4'h0;
    localparam logic [2:0]       MONO_FILTER   = 3'h6;
    localparam logic [7:0]       BLEND_ZERO    = 8'h00;
    // Compare encodings
    typedef enum logic [2:0] {
        compare_always_pass      = 3'b000,
        compare_never_pass       = 3'b001,
        compare_less             = 3'b010,
        compare_equal            = 3'b011,
        compare_less_or_equal    = 3'b100,
        compare_greater          = 3'b101,
        compare_not_equal        = 3'b110,
        compare_greater_or_equal = 3'b111
    } slcs_cmp_e;
    typedef enum logic {
        aniso_legacy               = 1'b0,
        elliptical_weighted_approx = 1'b1
    } slcs_aniso_e;
endpackage
`default_nettype wire

// file: tb/slcs_chk.sv
// Checker for the LOD clamp and shadow compare stage
`default_nettype none
module slcs_chk #(
    parameter int TEX_N = 4
) (
    // Clock and reset
    input wire logic             mclk,
    input wire logic             rst_b,
    // Sampler state
    input wire logic             aniso_alg_sel,
    input wire logic             trilinear_en,
    input wire logic [11:0]      lower_detail_clamp,
    input wire logic [11:0]      upper_detail_clamp,
    // Request
    input wire logic             req_valid,
    input wire logic             req_compare,
    input wire logic [12:0]      lod_in,
    input wire logic [12:0]      lod_bias,
    // Result
    input wire logic             res_valid,
    input wire logic             res_minify,
    input wire logic [11:0]      res_lod,
    input wire logic             res_elliptical,
    input wire logic [3:0]       res_level,
    input wire logic [7:0]       res_blend,
    input wire logic [TEX_N-1:0] res_cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_lower_wins: assert property (res_valid |-> res_lod >= $past(lower_detail_clamp))
        else $error("lod below lower clamp");
    a_upper_bound: assert property (res_valid && $past(lower_detail_clamp) <= $past(upper_detail_clamp) |->
        res_lod <= $past(upper_detail_clamp)) else $error("lod above upper clamp");
    a_upper_cap: assert property (res_valid && $past(lower_detail_clamp) <= 12'hE00 |-> res_lod <= 12'hE00)
        else $error("lod above fourteen");
    a_level_int: assert property (res_valid |-> res_level == res_lod[11:8])
        else $error("level not integer part");
    a_blend_frac: assert property (res_valid |-> res_blend == ($past(trilinear_en) ? res_lod[7:0] : 8'h00))
        else $error("blend wrong");
    a_ellip_sel: assert property (res_valid |-> res_elliptical == $past(aniso_alg_sel))
        else $error("aniso select wrong");
    a_cmp_off: assert property (res_valid && !$past(req_compare) |-> res_cmp == '0)
        else $error("compare without request");
    a_mag_zero: assert property (res_valid && $past(lod_in) == 13'h0000 && $past(lod_bias) == 13'h0000
        |-> !res_minify) else $error("zero lod minified");
    c_minify: cover property (res_valid && res_minify);
    c_compare: cover property (res_valid && |res_cmp);
    c_clamped: cover property (res_valid && res_lod == 12'hE00);
endmodule
bind slcs_lod_clamp slcs_chk #(.TEX_N(TEX_N)) u_chk (.mclk, .rst_b, .aniso_alg_sel, .trilinear_en, .req_valid,
    .req_compare, .lower_detail_clamp, .upper_detail_clamp, .res_lod, .lod_in, .lod_bias, .res_valid,
    .res_minify, .res_elliptical, .res_level, .res_blend, .res_cmp);
`default_nettype wire

// file: tb/slcs_eu_model.sv
// Execution-unit model issuing sample requests
`default_nettype none
module slcs_eu_model (
    // Clock
    input  wire logic        mclk,
    // Request to the sampler stage
    output var  logic        req_valid,
    output var  logic        req_compare,
    output var  logic [12:0] lod_in,
    output var  logic [12:0] lod_bias,
    output var  logic [15:0] ref_val,
    output var  logic [63:0] texels
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {req_valid, req_compare, lod_in, lod_bias, ref_val, texels} = '0;
    // One-cycle request; operands scrambled after release so stale values are never trusted
    task automatic issue(input logic [12:0] l, b, input logic c);
        @(negedge mclk);
        {req_valid, req_compare, lod_in, lod_bias} = {1'b1, c, l, b};
        {ref_val, texels} = {16'h0010, 64'h0010_0020_0010_0008};
        @(negedge mclk);
        {req_valid, req_compare, lod_in, lod_bias} = {1'b0, ~c, ~l, ~b};
        {ref_val, texels} = ~{ref_val, texels};
    endtask
endmodule
`default_nettype wire

// file: tb/slcs_lod_clamp_bench.sv
// Self-checking bench for the LOD clamp and shadow compare stage
`default_nettype none
module slcs_lod_clamp_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_b = 0, aniso_alg_sel = 0, trilinear_en = 0, req_valid, req_compare;
    logic res_valid, res_minify, res_elliptical, cfg_mono_err;
    logic [11:0] lower_detail_clamp = 0, upper_detail_clamp = 0, res_lod;
    logic [2:0] cmp_func = 0, min_filter = 0, mag_filter = 0;
    logic [12:0] lod_in, lod_bias;
    logic [15:0] ref_val;
    logic [63:0] texels;
    logic [3:0] res_level, res_cmp;
    logic [7:0] res_blend;
    int n_errors = 0, n_checks = 0;
    always #12.5 mclk = ~mclk;
    slcs_eu_model u_eu (.mclk, .req_valid, .req_compare, .lod_in, .lod_bias, .ref_val, .texels);
    slcs_lod_clamp u_dut (.mclk, .rst_b, .aniso_alg_sel, .lower_detail_clamp, .upper_detail_clamp, .cmp_func,
        .min_filter, .mag_filter, .trilinear_en, .req_valid, .lod_in, .lod_bias, .req_compare, .ref_val, .texels,
        .res_valid, .res_minify, .res_lod, .res_level, .res_blend, .res_elliptical, .res_cmp, .cfg_mono_err);
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Expectation is {minify, clamped lod}; select bit toggles every case
    task automatic clamp_case(input logic [12:0] l, b, input logic [11:0] lw, u, input logic t, input logic [12:0] e);
        {lower_detail_clamp, upper_detail_clamp, trilinear_en} = {lw, u, t};
        aniso_alg_sel = ~aniso_alg_sel;
        u_eu.issue(l, b, 1'b0);
        check("valid", res_valid, 1'b1);
        check("lod", {res_minify, res_lod}, e);
        check("level", res_level, e[11:8]);
        check("blend", res_blend, t ? e[7:0] : 8'h00);
        check("elliptical", res_elliptical, aniso_alg_sel);
        check("cmp off", res_cmp, 4'h0);
    endtask
    task automatic t_compare();
        logic [31:0] tbl = 32'hB51E_A40F;
        logic [7:0]  state_byte;
        for (int f = 0; f < 8; f++) begin
            state_byte = {4'h0, f[2:0], 1'b0};
            cmp_func = state_byte[3:1];
            u_eu.issue(13'h0000, 13'h0000, 1'b1);
            check("cmp", res_cmp, tbl[f*4 +: 4]);
        end
        $display("compare test done");
    endtask
    task automatic t_mono();
        for (int i = 0; i < 6; i++) begin
            lower_detail_clamp = i[0] ? 12'h100 : 12'h000;
            min_filter = (i[2:1] == 2'h1) ? slcs_pkg::MONO_FILTER : 3'h1;
            mag_filter = (i[2:1] == 2'h2) ? slcs_pkg::MONO_FILTER : 3'h1;
            repeat (2) @(negedge mclk);
            check("mono", cfg_mono_err, i[0] && i[2:1] != 2'h0);
        end
        $display("mono test done");
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        rst_b = 1;
        clamp_case(13'h0280, 13'h0000, 12'h100, 12'h200, 1, 13'h1200);
        clamp_case(13'h0080, 13'h0000, 12'h100, 12'h800, 0, 13'h1100);
        clamp_case(13'h0000, 13'h0000, 12'h180, 12'h800, 1, 13'h0180);
        clamp_case(13'h0500, 13'h0000, 12'h400, 12'h300, 0, 13'h1400);
        clamp_case(13'h0F80, 13'h0000, 12'h000, 12'hFFF, 0, 13'h1E00);
        clamp_case(13'h0100, 13'h1E00, 12'h000, 12'h800, 1, 13'h0000);
        clamp_case(13'h0100, 13'h00C0, 12'h000, 12'h800, 1, 13'h11C0);
        $display("clamp test done");
        t_compare();
        t_mono();
        print_verdict();
    end
    initial begin
        #20us;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
